// *** clock_reset_pkg.sv ***
// Constants, types and register map of the clock and supply-reset controller
//
// Summary of operation
// - Range 2: one flash wait state above 8 MHz, none from 32 kHz to 8 MHz.
// - Range 3: one flash wait state above 2.1 MHz, none at or below 2.1 MHz.
// - System clock from external fast osc, internal fast RC or multi-speed RC; PLL from first two.
// - Multi-speed RC offers seven frequencies, 65 kHz up to 4.2 MHz.
// - After any reset the system runs from the multi-speed RC near 2 MHz.
// - Enabled failure monitor moves system from failed external fast osc to internal RC.
// - Clock source changes at run time without glitch or stall at the core.
// - Separate clock gates for core, each peripheral and the memories.
// - Prescalers make AHB and two APB clocks, none above 32 MHz.
// - Calendar and display clocks each pick slow RC, slow osc or fast osc.
// - Slow RC clocks the watchdog and can be measured against the fast RC.
// - PLL fed from the external fast osc gives a dedicated 48 MHz clock to the USB interface.
// - The clock output pin carries one selected internal clock.
// - Multi-speed RC is trimmable by software, measurable against the slow osc.
// - Device held in reset while supply is below power-down or brownout level.
// - Brownout reset offers five thresholds chosen by option settings.
// - Once supply is up, option settings load, may change or disable brownout.
// - Supply monitor: seven levels, event on falling below and/or rising above.
// - Internal reference voltage may switch off automatically in Stop mode.
// - Main regulator in Run and Sleep, low-power one in low-power run, low-power sleep and Stop, off in Standby.
// - Range 1: one flash wait state above 16 MHz, none from 32 kHz to 16 MHz.
package clock_reset_pkg;

	// ************
	// Bus and map
	// ************
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CFG = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_MSI = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_STAT = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_FLAG = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_GATE_AHB = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_GATE_APB1 = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_GATE_APB2 = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_PWR = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_MEAS = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_OPT = 12'h028;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_type;

	// ************
	// Field positions
	// ************
	localparam int CTRL_CSS_EN = 6;
	localparam int CTRL_CSS_IE = 7;
	localparam int CTRL_PLL_SRC = 8;
	localparam int CFG_SRC = 0;
	localparam int CFG_AHB = 2;
	localparam int CFG_APB1 = 6;
	localparam int CFG_APB2 = 9;
	localparam int CFG_MCO = 12;
	localparam int CFG_RTC = 15;
	localparam int CFG_LCD = 17;
	localparam int MSI_TRIM = 3;
	localparam int FLAG_CSS = 0;
	localparam int FLAG_PVD = 1;
	localparam int FLAG_ERR = 2;
	localparam int PWR_LVL = 1;
	localparam int PWR_RISE = 4;
	localparam int PWR_FALL = 5;
	localparam int PWR_VREF = 6;
	localparam int PWR_VOS = 7;

	// ************
	// Sources, frequencies and limits
	// ************
	localparam logic [1:0] SRC_MSI = 2'h0;
	localparam logic [1:0] SRC_HSI = 2'h1;
	localparam logic [1:0] SRC_HSE = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam int OSC_MSI = 0;
	localparam int OSC_HSI = 1;
	localparam int OSC_HSE = 2;
	localparam int OSC_PLL = 3;
	localparam int OSC_LSE = 4;
	localparam int OSC_LSI = 5;
	localparam logic [15:0] HSI_KHZ = 16'h3e80;
	localparam logic [15:0] BUS_MAX_KHZ = 16'h7d00;
	localparam logic [15:0] WS_LIM_R1_KHZ = 16'h3e80;
	localparam logic [15:0] WS_LIM_R2_KHZ = 16'h1f40;
	localparam logic [15:0] WS_LIM_R3_KHZ = 16'h0834;
	localparam logic [1:0] VOS_R1 = 2'h1;
	localparam logic [1:0] VOS_R2 = 2'h2;
	localparam logic [3:0] AHB_DIV_MAX = 4'h9;
	localparam logic [2:0] APB_DIV_MAX = 3'h4;
	localparam logic [2:0] MSI_RANGE_MAX = 3'h6;
	localparam logic [2:0] PVD_LVL_MAX = 3'h6;
	localparam logic [2:0] BOR_LVL_MAX = 3'h4;

	// ************
	// Reset values
	// ************
	localparam logic [5:0] RST_OSC_ON = 6'h01;
	localparam logic [2:0] RST_MSI_RANGE = 3'h5;
	localparam logic [7:0] RST_MSI_TRIM = 8'h00;
	localparam logic [31:0] RST_GATE = 32'h00000000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_WS_UP = 3'b010,
		ST_SWITCH = 3'b011,
		ST_WS_DOWN = 3'b100
	} sw_state_type;

	typedef enum logic [2:0] {
		PM_RUN = 3'b000,
		PM_SLEEP = 3'b001,
		PM_LP_RUN = 3'b010,
		PM_LP_SLEEP = 3'b011,
		PM_STOP = 3'b100,
		PM_STANDBY = 3'b101
	} pwr_mode_type;

	typedef enum logic [1:0] {
		REG_MAIN = 2'b00,
		REG_LOW = 2'b01,
		REG_OFF = 2'b10
	} reg_mode_type;

endpackage

// *** clock_reset_control.sv ***
// Clock selection, prescaling, gating and supply-reset control with APB registers
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module clock_reset_control
	import clock_reset_pkg::*;
#(
	parameter logic [15:0] HSE_KHZ = 16'h1f40,
	parameter logic [15:0] PLL_KHZ = 16'h7d00
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire apb_req_type apb_in,
	output apb_rsp_type apb_out,
	input wire logic [5:0] osc_rdy,
	input wire logic hse_fail,
	input wire logic lsi_tick,
	input wire logic lse_tick,
	input wire logic wdg_active,
	input wire pwr_mode_type pwr_mode,
	input wire logic supply_ok,
	input wire logic [4:0] bor_cmp,
	input wire logic [6:0] pvd_above,
	input wire logic [2:0] opt_bor_lvl,
	input wire logic opt_bor_off,
	output logic [5:0] osc_en,
	output logic [1:0] sys_src_sel,
	output logic pll_src_sel,
	output logic flash_ws,
	output logic hclk_en,
	output logic pclk1_en,
	output logic pclk2_en,
	output logic core_clk_on,
	output logic [31:0] gate_ahb,
	output logic [31:0] gate_apb1,
	output logic [31:0] gate_apb2,
	output logic [1:0] rtc_src_sel,
	output logic [1:0] lcd_src_sel,
	output logic usb_clk_on,
	output logic [2:0] clk_out_sel,
	output logic [2:0] msi_range,
	output logic [7:0] msi_trim,
	output logic sys_reset_hold,
	output reg_mode_type reg_mode,
	output logic vref_on,
	output logic css_irq,
	output logic pvd_irq
);

	// ************
	// State
	// ************
	typedef struct packed {
		apb_rsp_type rsp;
		logic [5:0] osc_on;
		logic [5:0] osc_en;
		logic css_en, css_ie, pll_src;
		logic [1:0] req_src;
		logic [3:0] req_ahb;
		logic [2:0] apb1_div, apb2_div;
		logic [2:0] mco_sel;
		logic [1:0] rtc_sel, lcd_sel;
		logic [2:0] msi_range;
		logic [7:0] msi_trim;
		logic [1:0] act_src;
		logic [3:0] act_ahb;
		logic ws;
		sw_state_type st;
		logic pend, css_flag, pvd_flag, cfg_err;
		logic [31:0] gate_ahb, gate_apb1, gate_apb2;
		logic pvd_en;
		logic [2:0] pvd_lvl;
		logic pvd_rise, pvd_fall, pvd_prev, vref_auto;
		logic [1:0] vos;
		logic meas_sel;
		logic [15:0] meas_cnt, meas_val;
		logic opt_done;
		logic [2:0] bor_lvl;
		logic bor_off;
		logic hold;
		logic [8:0] ahb_cnt;
		logic [3:0] apb1_cnt, apb2_cnt;
		logic hclk_en, pclk1_en, pclk2_en, core_on, usb_on;
		reg_mode_type reg_mode;
		logic vref_on, css_irq, pvd_irq;
	} state_type;

	state_type s_q;
	state_type s_d;

	// ************
	// Helper functions
	// ************
	// Multi-speed RC frequency in kHz per range code
	function automatic logic [15:0] msi_khz(input logic [2:0] r);
		case (r)
			3'h0: msi_khz = 16'h0041;
			3'h1: msi_khz = 16'h0083;
			3'h2: msi_khz = 16'h0106;
			3'h3: msi_khz = 16'h020c;
			3'h4: msi_khz = 16'h0418;
			3'h5: msi_khz = 16'h0831;
			default: msi_khz = 16'h1062;
		endcase
	endfunction

	// Frequency of a system clock root in kHz
	function automatic logic [15:0] src_khz(input logic [1:0] src, input logic [2:0] r);
		case (src)
			SRC_MSI: src_khz = msi_khz(r);
			SRC_HSI: src_khz = HSI_KHZ;
			SRC_HSE: src_khz = HSE_KHZ;
			default: src_khz = PLL_KHZ;
		endcase
	endfunction

	// Flash wait states needed for a core frequency in a voltage range
	function automatic logic ws_need(input logic [15:0] khz, input logic [1:0] vos);
		case (vos)
			VOS_R1: ws_need = khz > WS_LIM_R1_KHZ;
			VOS_R2: ws_need = khz > WS_LIM_R2_KHZ;
			default: ws_need = khz > WS_LIM_R3_KHZ;
		endcase
	endfunction

	// Low counter bits that must be all ones for a divide by two to the d
	function automatic logic [8:0] div_mask(input logic [3:0] d);
		div_mask = 9'((10'h001 << d) - 10'h001);
	endfunction

	// ************
	// Next state
	// ************
	always_comb begin
		logic acc;
		logic wr;
		logic hit;
		logic [31:0] rd;
		logic [15:0] new_khz;
		logic [15:0] act_khz;
		logic [15:0] req_khz;
		logic [3:0] ahb_w;
		logic [2:0] lvl_w;
		logic pvd_now;
		logic hse_based;
		logic stop_like;
		logic [8:0] p1_mask;
		logic [8:0] p2_mask;
		s_d = s_q;
		acc = apb_in.psel & apb_in.penable;
		wr = acc & apb_in.pwrite & s_q.rsp.pready;
		hit = 1'b1;
		rd = 32'h00000000;
		new_khz = 16'h0000;
		ahb_w = 4'h0;
		lvl_w = 3'h0;
		p1_mask = div_mask({1'b0, s_q.apb1_div});
		p2_mask = div_mask({1'b0, s_q.apb2_div});
		act_khz = src_khz(s_q.act_src, s_q.msi_range) >> s_q.act_ahb;
		req_khz = src_khz(s_q.req_src, s_q.msi_range) >> s_q.req_ahb;
		hse_based = s_q.act_src == SRC_HSE || (s_q.act_src == SRC_PLL && !s_q.pll_src);

		// Register read mux and decode
		case (apb_in.paddr)
			OFS_CTRL: rd = {23'h0, s_q.pll_src, s_q.css_ie, s_q.css_en, s_q.osc_on};
			OFS_CFG: rd = {13'h0, s_q.lcd_sel, s_q.rtc_sel, s_q.mco_sel, s_q.apb2_div, s_q.apb1_div,
				s_q.req_ahb, s_q.req_src};
			OFS_MSI: rd = {21'h0, s_q.msi_trim, s_q.msi_range};
			OFS_STAT: rd = {15'h0, s_q.st, s_q.pend, s_q.act_ahb, s_q.ws, s_q.act_src, osc_rdy};
			OFS_FLAG: rd = {29'h0, s_q.cfg_err, s_q.pvd_flag, s_q.css_flag};
			OFS_GATE_AHB: rd = s_q.gate_ahb;
			OFS_GATE_APB1: rd = s_q.gate_apb1;
			OFS_GATE_APB2: rd = s_q.gate_apb2;
			OFS_PWR: rd = {23'h0, s_q.vos, s_q.vref_auto, s_q.pvd_fall, s_q.pvd_rise, s_q.pvd_lvl, s_q.pvd_en};
			OFS_MEAS: rd = {15'h0, s_q.meas_sel, s_q.meas_val};
			OFS_OPT: rd = {28'h0, s_q.bor_off, s_q.bor_lvl};
			default: hit = 1'b0;
		endcase

		// APB answer one cycle into the access phase
		s_d.rsp.pready = acc & !s_q.rsp.pready;
		if (acc && !s_q.rsp.pready) begin
			s_d.rsp.prdata = apb_in.pwrite ? 32'h00000000 : rd;
			s_d.rsp.pslverr = !hit;
		end

		// Register writes at the completing edge
		if (wr && hit) begin
			case (apb_in.paddr)
				OFS_CTRL: begin
					s_d.osc_on = apb_in.pwdata[5:0];
					s_d.css_en = apb_in.pwdata[CTRL_CSS_EN];
					s_d.css_ie = apb_in.pwdata[CTRL_CSS_IE];
					s_d.pll_src = apb_in.pwdata[CTRL_PLL_SRC];
				end
				OFS_CFG: begin
					ahb_w = apb_in.pwdata[CFG_AHB +: 4] > AHB_DIV_MAX ? AHB_DIV_MAX : apb_in.pwdata[CFG_AHB +: 4];
					new_khz = src_khz(apb_in.pwdata[CFG_SRC +: 2], s_q.msi_range) >> ahb_w;
					if (new_khz > BUS_MAX_KHZ) begin
						s_d.cfg_err = 1'b1;
					end else begin
						s_d.req_src = apb_in.pwdata[CFG_SRC +: 2];
						s_d.req_ahb = ahb_w;
						s_d.pend = 1'b1;
					end
					s_d.apb1_div = apb_in.pwdata[CFG_APB1 +: 3] > APB_DIV_MAX ? APB_DIV_MAX
						: apb_in.pwdata[CFG_APB1 +: 3];
					s_d.apb2_div = apb_in.pwdata[CFG_APB2 +: 3] > APB_DIV_MAX ? APB_DIV_MAX
						: apb_in.pwdata[CFG_APB2 +: 3];
					s_d.mco_sel = apb_in.pwdata[CFG_MCO +: 3];
					s_d.rtc_sel = apb_in.pwdata[CFG_RTC +: 2];
					s_d.lcd_sel = apb_in.pwdata[CFG_LCD +: 2];
				end
				OFS_MSI: begin
					// Range changes only while another root drives the system
					if (s_q.act_src != SRC_MSI) begin
						s_d.msi_range = apb_in.pwdata[2:0] > MSI_RANGE_MAX ? MSI_RANGE_MAX : apb_in.pwdata[2:0];
					end
					s_d.msi_trim = apb_in.pwdata[MSI_TRIM +: 8];
				end
				OFS_FLAG: begin
					if (apb_in.pwdata[FLAG_CSS]) s_d.css_flag = 1'b0;
					if (apb_in.pwdata[FLAG_PVD]) s_d.pvd_flag = 1'b0;
					if (apb_in.pwdata[FLAG_ERR]) s_d.cfg_err = 1'b0;
				end
				OFS_GATE_AHB: s_d.gate_ahb = apb_in.pwdata;
				OFS_GATE_APB1: s_d.gate_apb1 = apb_in.pwdata;
				OFS_GATE_APB2: s_d.gate_apb2 = apb_in.pwdata;
				OFS_PWR: begin
					lvl_w = apb_in.pwdata[PWR_LVL +: 3];
					s_d.pvd_en = apb_in.pwdata[0];
					s_d.pvd_lvl = lvl_w > PVD_LVL_MAX ? PVD_LVL_MAX : lvl_w;
					s_d.pvd_rise = apb_in.pwdata[PWR_RISE];
					s_d.pvd_fall = apb_in.pwdata[PWR_FALL];
					s_d.vref_auto = apb_in.pwdata[PWR_VREF];
					if (apb_in.pwdata[PWR_VOS +: 2] != 2'h0) s_d.vos = apb_in.pwdata[PWR_VOS +: 2];
				end
				OFS_MEAS: s_d.meas_sel = apb_in.pwdata[16];
				default: ;
			endcase
		end

		// Source switch sequencer
		case (s_q.st)
			ST_IDLE: begin
				if (ws_need(act_khz, s_q.vos)) s_d.ws = 1'b1;
				if (s_q.pend) begin
					s_d.pend = wr && apb_in.paddr == OFS_CFG ? s_d.pend : 1'b0;
					s_d.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Old source stays until the new one is stable
				if (osc_rdy[s_q.req_src] && s_q.osc_on[s_q.req_src]) begin
					s_d.st = ws_need(req_khz, s_q.vos) && !s_q.ws ? ST_WS_UP : ST_SWITCH;
				end
			end
			ST_WS_UP: begin
				s_d.ws = 1'b1;
				s_d.st = ST_SWITCH;
			end
			ST_SWITCH: begin
				// Root and divider change together, dividers restart clean
				s_d.act_src = s_q.req_src;
				s_d.act_ahb = s_q.req_ahb;
				s_d.ahb_cnt = 9'h000;
				s_d.apb1_cnt = 4'h0;
				s_d.apb2_cnt = 4'h0;
				s_d.st = !ws_need(req_khz, s_q.vos) && s_q.ws ? ST_WS_DOWN : ST_IDLE;
			end
			ST_WS_DOWN: begin
				s_d.ws = 1'b0;
				s_d.st = ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase

		// Failure monitor forces the internal fast RC, highest priority
		if (s_q.css_en && hse_fail && hse_based) begin
			s_d.css_flag = 1'b1;
			// Rescue requested once, then the sequencer is left to finish it
			if (s_q.req_src != SRC_HSI || s_q.st == ST_IDLE) begin
				s_d.osc_on[OSC_HSI] = 1'b1;
				s_d.req_src = SRC_HSI;
				s_d.req_ahb = s_q.act_ahb;
				s_d.st = ST_WAIT;
			end
		end

		// Bus clock enables from the prescalers
		s_d.ahb_cnt = s_d.ahb_cnt + 9'h001;
		s_d.hclk_en = (s_q.ahb_cnt & div_mask(s_q.act_ahb)) == div_mask(s_q.act_ahb);
		s_d.pclk1_en = 1'b0;
		s_d.pclk2_en = 1'b0;
		if (s_d.hclk_en && s_q.st != ST_SWITCH) begin
			s_d.apb1_cnt = s_q.apb1_cnt + 4'h1;
			s_d.apb2_cnt = s_q.apb2_cnt + 4'h1;
			s_d.pclk1_en = (s_q.apb1_cnt & p1_mask[3:0]) == p1_mask[3:0];
			s_d.pclk2_en = (s_q.apb2_cnt & p2_mask[3:0]) == p2_mask[3:0];
		end

		// Slow clock period counted in core cycles
		s_d.meas_cnt = s_q.meas_cnt + 16'h0001;
		if (s_q.meas_sel ? lse_tick : lsi_tick) begin
			s_d.meas_val = s_q.meas_cnt;
			s_d.meas_cnt = 16'h0000;
		end

		// Supply level monitor crossing events, set wins over clear
		pvd_now = pvd_above[s_q.pvd_lvl];
		s_d.pvd_prev = pvd_now;
		if (s_q.pvd_en && ((s_q.pvd_fall && s_q.pvd_prev && !pvd_now)
			|| (s_q.pvd_rise && !s_q.pvd_prev && pvd_now))) begin
			s_d.pvd_flag = 1'b1;
		end

		// Option settings load once supply is up
		if (supply_ok && !s_q.opt_done) begin
			s_d.opt_done = 1'b1;
			s_d.bor_lvl = opt_bor_lvl > BOR_LVL_MAX ? BOR_LVL_MAX : opt_bor_lvl;
			s_d.bor_off = opt_bor_off;
		end
		s_d.hold = !supply_ok || !s_q.opt_done || (!s_q.bor_off && !bor_cmp[s_q.bor_lvl]);

		// Mode dependent outputs
		stop_like = pwr_mode == PM_STOP || pwr_mode == PM_STANDBY;
		s_d.osc_en = s_d.osc_on;
		s_d.osc_en[s_d.act_src] = 1'b1;
		s_d.osc_en[OSC_LSI] = s_d.osc_on[OSC_LSI] || wdg_active;
		if (s_d.act_src == SRC_PLL) s_d.osc_en[s_d.pll_src ? OSC_HSI : OSC_HSE] = 1'b1;
		if (stop_like) s_d.osc_en[OSC_PLL:OSC_MSI] = 4'h0;
		s_d.core_on = pwr_mode == PM_RUN || pwr_mode == PM_LP_RUN;
		s_d.usb_on = s_q.osc_en[OSC_PLL] && osc_rdy[OSC_PLL] && !s_q.pll_src && !stop_like;
		case (pwr_mode)
			PM_RUN, PM_SLEEP: s_d.reg_mode = REG_MAIN;
			PM_STANDBY: s_d.reg_mode = REG_OFF;
			default: s_d.reg_mode = REG_LOW;
		endcase
		s_d.vref_on = !(s_q.vref_auto && pwr_mode == PM_STOP) && pwr_mode != PM_STANDBY;
		s_d.css_irq = s_d.css_flag && s_q.css_ie;
		s_d.pvd_irq = s_d.pvd_flag;
	end

	// ************
	// Registers
	// ************
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.osc_on <= RST_OSC_ON;
			s_q.osc_en <= RST_OSC_ON;
			s_q.req_src <= SRC_MSI;
			s_q.act_src <= SRC_MSI;
			s_q.msi_range <= RST_MSI_RANGE;
			s_q.msi_trim <= RST_MSI_TRIM;
			s_q.gate_ahb <= RST_GATE;
			s_q.gate_apb1 <= RST_GATE;
			s_q.gate_apb2 <= RST_GATE;
			s_q.vos <= VOS_R2;
			s_q.st <= ST_IDLE;
			s_q.hold <= 1'b1;
			s_q.reg_mode <= REG_MAIN;
			s_q.vref_on <= 1'b1;
			s_q.core_on <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops
	assign apb_out = s_q.rsp;
	assign osc_en = s_q.osc_en;
	assign sys_src_sel = s_q.act_src;
	assign pll_src_sel = s_q.pll_src;
	assign flash_ws = s_q.ws;
	assign hclk_en = s_q.hclk_en;
	assign pclk1_en = s_q.pclk1_en;
	assign pclk2_en = s_q.pclk2_en;
	assign core_clk_on = s_q.core_on;
	assign gate_ahb = s_q.gate_ahb;
	assign gate_apb1 = s_q.gate_apb1;
	assign gate_apb2 = s_q.gate_apb2;
	assign rtc_src_sel = s_q.rtc_sel;
	assign lcd_src_sel = s_q.lcd_sel;
	assign usb_clk_on = s_q.usb_on;
	assign clk_out_sel = s_q.mco_sel;
	assign msi_range = s_q.msi_range;
	assign msi_trim = s_q.msi_trim;
	assign sys_reset_hold = s_q.hold;
	assign reg_mode = s_q.reg_mode;
	assign vref_on = s_q.vref_on;
	assign css_irq = s_q.css_irq;
	assign pvd_irq = s_q.pvd_irq;

endmodule // clock_reset_control

// *** clock_reset_checker.sv ***
// Port-level assertions for the clock and supply-reset controller
`timescale 1ns/1ps
module clock_reset_checker
	import clock_reset_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire apb_req_type apb_in,
	input wire apb_rsp_type apb_out,
	input wire logic [5:0] osc_rdy,
	input wire pwr_mode_type pwr_mode,
	input wire logic supply_ok,
	input wire logic [5:0] osc_en,
	input wire logic [1:0] sys_src_sel,
	input wire logic pll_src_sel,
	input wire logic hclk_en,
	input wire logic pclk1_en,
	input wire logic core_clk_on,
	input wire logic usb_clk_on,
	input wire logic [2:0] msi_range,
	input wire logic sys_reset_hold,
	input wire reg_mode_type reg_mode
);
	// ************
	// Clocking and helper state
	// ************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	logic [5:0] rdy_q;

	// Ready flags one cycle back, to judge a root change
	always_ff @(posedge core_clk) begin
		rdy_q <= osc_rdy;
	end

	// ************
	// Properties
	// ************
	start_clock_a: assert property ($rose(rst_b) |-> sys_src_sel == SRC_MSI && msi_range == RST_MSI_RANGE
		&& osc_en == RST_OSC_ON && sys_reset_hold) else $error("reset state wrong");
	src_stable_a: assert property ($past(rst_b) && $changed(sys_src_sel) |-> rdy_q[sys_src_sel])
		else $error("root switched before ready");
	supply_hold_a: assert property (!supply_ok |-> ##[1:2] sys_reset_hold)
		else $error("reset not held on low supply");
	reg_main_a: assert property ((pwr_mode == PM_RUN) [*2] |-> reg_mode == REG_MAIN)
		else $error("main regulator not used in run");
	reg_off_a: assert property ((pwr_mode == PM_STANDBY) [*3] |-> reg_mode == REG_OFF)
		else $error("regulator not off in standby");
	stop_core_a: assert property ((pwr_mode == PM_STOP) [*2] |-> !core_clk_on && osc_en[3:0] == 4'h0)
		else $error("core clock or fast oscillators on in stop");
	usb_source_a: assert property (usb_clk_on |-> osc_en[OSC_PLL] && !pll_src_sel)
		else $error("usb clock without pll from fast osc");
	apb_bus_a: assert property (pclk1_en |-> hclk_en)
		else $error("apb enable outside ahb enable");
	ready_time_a: assert property ($rose(apb_in.penable) && apb_in.psel |=> apb_out.pready ##1 !apb_out.pready)
		else $error("bus answer not on second access cycle");
endmodule // clock_reset_checker

bind clock_reset_control clock_reset_checker clock_reset_checker_inst (.core_clk(core_clk), .rst_b(rst_b),
	.apb_in(apb_in), .apb_out(apb_out), .osc_rdy(osc_rdy), .pwr_mode(pwr_mode), .supply_ok(supply_ok),
	.osc_en(osc_en), .sys_src_sel(sys_src_sel), .pll_src_sel(pll_src_sel), .hclk_en(hclk_en),
	.pclk1_en(pclk1_en), .core_clk_on(core_clk_on), .usb_clk_on(usb_clk_on), .msi_range(msi_range),
	.sys_reset_hold(sys_reset_hold), .reg_mode(reg_mode));

// *** test_clock_reset_control.sv ***
// Register-level testbench for the clock and supply-reset controller
`timescale 1ns/1ps
module test_clock_reset_control
	import clock_reset_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	apb_req_type apb_in = '0;
	apb_rsp_type apb_out;
	logic [5:0] osc_rdy = 6'h21;
	logic hse_fail = 1'b0;
	pwr_mode_type pwr_mode = PM_RUN;
	logic supply_ok = 1'b1;
	logic [4:0] bor_cmp = 5'h1f;
	logic [6:0] pvd_above = 7'h7f;
	logic [5:0] osc_en;
	logic [1:0] sys_src_sel, rtc_src_sel, lcd_src_sel;
	logic flash_ws, usb_clk_on, sys_reset_hold, vref_on, css_irq, pvd_irq;
	logic [31:0] gate_apb1, r;
	logic [2:0] clk_out_sel, msi_range;
	logic [7:0] msi_trim;
	reg_mode_type reg_mode;
	logic e;
	int fail_count = 0;
	int cmp_count = 0;
	pwr_mode_type modes [6] = '{PM_RUN, PM_SLEEP, PM_LP_RUN, PM_LP_SLEEP, PM_STOP, PM_STANDBY};
	reg_mode_type regs [6] = '{REG_MAIN, REG_MAIN, REG_LOW, REG_LOW, REG_LOW, REG_OFF};
	logic [5:0] vref_exp = 6'h0f;

	// 125 MHz clock
	always #4 core_clk = ~core_clk;

	clock_reset_control clock_reset_control_inst (.core_clk(core_clk), .rst_b(rst_b), .apb_in(apb_in),
		.apb_out(apb_out), .osc_rdy(osc_rdy), .hse_fail(hse_fail), .lsi_tick(1'b0), .lse_tick(1'b0),
		.wdg_active(1'b0), .pwr_mode(pwr_mode), .supply_ok(supply_ok), .bor_cmp(bor_cmp), .pvd_above(pvd_above),
		.opt_bor_lvl(3'h2), .opt_bor_off(1'b0), .osc_en(osc_en), .sys_src_sel(sys_src_sel), .pll_src_sel(),
		.flash_ws(flash_ws), .hclk_en(), .pclk1_en(), .pclk2_en(), .core_clk_on(), .gate_ahb(),
		.gate_apb1(gate_apb1), .gate_apb2(), .rtc_src_sel(rtc_src_sel), .lcd_src_sel(lcd_src_sel),
		.usb_clk_on(usb_clk_on), .clk_out_sel(clk_out_sel), .msi_range(msi_range), .msi_trim(msi_trim),
		.sys_reset_hold(sys_reset_hold), .reg_mode(reg_mode), .vref_on(vref_on), .css_irq(css_irq),
		.pvd_irq(pvd_irq));

	// ************
	// Tasks
	// ************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		apb_in.psel <= 1'b1;
		apb_in.pwrite <= wr;
		apb_in.paddr <= a;
		apb_in.pwdata <= wd;
		@(posedge core_clk);
		apb_in.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (apb_out.pready !== 1'b1 && n < 40);
		r = apb_out.prdata;
		e = apb_out.pslverr;
		apb_in.psel <= 1'b0;
		apb_in.penable <= 1'b0;
		check(32'(apb_out.pready), 32'h1, "bus answer");
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Bounded wait for a new system root
	task automatic wait_src(input logic [1:0] s);
		int n;
		n = 0;
		while (sys_src_sel !== s && n < 60) begin
			@(posedge core_clk);
			n++;
		end
		check(32'(sys_src_sel), 32'(s), "system root");
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ************
	// Tests
	// ************
	initial begin
		tick(5);
		rst_b <= 1'b1;
		tick(1);
		check(32'(sys_src_sel), 32'(SRC_MSI), "start root");
		check(32'(msi_range), 32'(RST_MSI_RANGE), "start range");
		$display("reset test done");
		apb_xfer(1'b1, OFS_CTRL, 32'h3);
		tick(640);
		apb_xfer(1'b1, OFS_CFG, 32'h5);
		tick(8);
		check(32'(sys_src_sel), 32'(SRC_MSI), "root kept while unready");
		osc_rdy <= 6'h23;
		wait_src(SRC_HSI);
		check(32'(flash_ws), 32'h0, "range 2 at 8 MHz");
		tick(640);
		apb_xfer(1'b1, OFS_CFG, 32'h1);
		tick(8);
		check(32'(flash_ws), 32'h1, "range 2 at 16 MHz");
		apb_xfer(1'b1, OFS_MSI, 32'h2d7);
		tick(1);
		check(32'(msi_range), 32'h6, "range clamp");
		check(32'(msi_trim), 32'h5a, "trim");
		tick(640);
		apb_xfer(1'b1, OFS_CFG, 32'h0);
		wait_src(SRC_MSI);
		tick(8);
		check(32'(flash_ws), 32'h0, "range 2 at 4.2 MHz");
		apb_xfer(1'b1, OFS_PWR, 32'h180);
		tick(8);
		check(32'(flash_ws), 32'h1, "range 3 at 4.2 MHz");
		$display("switch test done");
		apb_xfer(1'b1, OFS_PWR, 32'h080);
		osc_rdy <= 6'h3f;
		apb_xfer(1'b1, OFS_CTRL, 32'hcf);
		tick(640);
		apb_xfer(1'b1, OFS_CFG, 32'h35002);
		wait_src(SRC_HSE);
		tick(8);
		check(32'(flash_ws), 32'h0, "range 1 at 8 MHz");
		check(32'(clk_out_sel), 32'h5, "clock out");
		check({rtc_src_sel, lcd_src_sel}, 32'h9, "slow clock selects");
		tick(640);
		apb_xfer(1'b1, OFS_CFG, 32'h35007);
		wait_src(SRC_PLL);
		tick(640);
		apb_xfer(1'b1, OFS_CFG, 32'h35003);
		tick(8);
		check(32'(flash_ws), 32'h1, "range 1 at 32 MHz");
		check(32'(usb_clk_on), 32'h1, "usb clock");
		hse_fail <= 1'b1;
		wait_src(SRC_HSI);
		check(32'(css_irq), 32'h1, "failure event");
		hse_fail <= 1'b0;
		apb_xfer(1'b1, OFS_FLAG, 32'h1);
		tick(2);
		check(32'(css_irq), 32'h0, "failure cleared");
		$display("failure test done");
		apb_xfer(1'b0, 12'h0fc, 32'h0);
		check(32'(e), 32'h1, "unmapped error");
		check(r, 32'h0, "unmapped data");
		apb_xfer(1'b0, OFS_OPT, 32'h0);
		check(r, 32'h2, "option load");
		apb_xfer(1'b1, OFS_GATE_APB1, 32'ha5a50f0f);
		tick(1);
		check(gate_apb1, 32'ha5a50f0f, "gate");
		apb_xfer(1'b0, OFS_GATE_APB1, 32'h0);
		check(r, 32'ha5a50f0f, "gate read");
		$display("register test done");
		bor_cmp <= 5'h1b;
		tick(3);
		check(32'(sys_reset_hold), 32'h1, "brownout hold");
		bor_cmp <= 5'h1f;
		supply_ok <= 1'b0;
		tick(3);
		check(32'(sys_reset_hold), 32'h1, "supply hold");
		supply_ok <= 1'b1;
		tick(3);
		check(32'(sys_reset_hold), 32'h0, "supply release");
		// Supply monitor at level 3, event on falling below only
		apb_xfer(1'b1, OFS_PWR, 32'h0a7);
		tick(2);
		pvd_above <= 7'h77;
		tick(3);
		check(32'(pvd_irq), 32'h1, "supply below level");
		pvd_above <= 7'h7f;
		apb_xfer(1'b1, OFS_FLAG, 32'h2);
		tick(2);
		check(32'(pvd_irq), 32'h0, "supply event cleared");
		$display("supply test done");
		apb_xfer(1'b1, OFS_PWR, 32'h0c0);
		for (int i = 0; i < 6; i++) begin
			pwr_mode <= modes[i];
			tick(4);
			check(32'(reg_mode), 32'(regs[i]), "regulator");
			check(32'(vref_on), 32'(vref_exp[i]), "reference");
		end
		pwr_mode <= PM_RUN;
		tick(4);
		$display("mode test done");
		wrap_up();
	end

	// Watchdog far beyond the few thousand cycles the tests need
	initial begin
		#400000;
		fail_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule // test_clock_reset_control
